// ---- hw/asc_pkg.sv ----
// Package for the analog switch control block: register layout, field positions and carriers.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package asc_pkg;

	localparam int          ASC_DATA_W        = 8;
	localparam int          ASC_ADDR_W        = 4;
	localparam int          ASC_NUM_PINS      = 4;
	localparam int          ASC_NUM_SW        = 4;

	// Register offsets.
	localparam logic [3:0]  ASC_SWITCH_CONTROL_ADDR = 4'h0;
	localparam logic [3:0]  ASC_PIN_ASSIGN_ADDR     = 4'h1;
	localparam logic [3:0]  ASC_PIN_LEVEL_ADDR      = 4'h2;
	localparam logic [3:0]  ASC_PULSE_CFG_ADDR      = 4'h3;
	localparam logic [3:0]  ASC_SWITCH_STATE_ADDR   = 4'h4;

	// Switch control field positions.
	localparam int          ASC_BUF_A_BIT     = 7;
	localparam int          ASC_BUF_B_BIT     = 6;
	localparam int          ASC_CO1_MODE_BIT  = 5;
	localparam int          ASC_CO1_DRIVE_BIT = 4;
	localparam int          ASC_CO2_MODE_BIT  = 3;
	localparam int          ASC_CO2_DRIVE_BIT = 2;
	localparam logic [7:0]  ASC_SWCTL_MASK    = 8'hfc;

	// Pulse configuration field positions.
	localparam int          ASC_PA_HIGH_BIT   = 0;
	localparam int          ASC_PA_LOW_BIT    = 1;
	localparam int          ASC_PB_HIGH_BIT   = 2;
	localparam int          ASC_PB_LOW_BIT    = 3;
	localparam int          ASC_PCO1_BIT      = 4;
	localparam int          ASC_PCO2_BIT      = 5;

	// Switch index used in pin assignment and state vectors.
	localparam int          ASC_SW_A          = 0;
	localparam int          ASC_SW_B          = 1;
	localparam int          ASC_SW_CO1        = 2;
	localparam int          ASC_SW_CO2        = 3;

	localparam logic [7:0]  ASC_RESET_VAL     = 8'h00;

	// Pin level register fields and read-back fill values.
	localparam int          ASC_LEVEL_LSB     = 0;
	localparam int          ASC_ENABLE_LSB    = 4;
	localparam logic [7:0]  ASC_RDATA_IDLE    = 8'h00;
	localparam logic [1:0]  ASC_STATE_PAD     = 2'b00;

	typedef struct packed {
		logic       buf_a_closed;
		logic       buf_b_closed;
		logic       co1_no_closed;
		logic       co1_nc_closed;
		logic       co2_no_closed;
		logic       co2_nc_closed;
	} asc_switch_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} asc_bus_req_t;

endpackage : asc_pkg

// ---- hw/asc_top.sv ----
// Analog switch control: register file and combinational switch drive logic.
// Assumes user pins and pulse output are synchronous to clk_in.
// Contract
// - Eight-bit switch control register, fixed field order.
// - Buffer A closes on bit, pin or pulse.
// - Buffer B uses the same three-way OR.
// - Changeover one drive is OR of three.
// - Mode zero: both terminals follow drive term.
// - Mode one: drive toggles normally closed/open terminals.
// - Pin counts asserted per its active level.
// - Unassigned pin contributes zero.
// - Unassigned pulse output contributes zero.
// - Buffer A pulse sense from high/low pair.
// - Buffer B pulse sense from own pair.
// - Changeover one pulse sense from single bit.
// - Reset clears all six control bits.
// - Changeover two behaves like changeover one.
// - Changeover two pulse sense from own bit.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module asc_top (
	// Clock and reset.
	input  wire logic                 clk_in,
	input  wire logic                 srst_in,
	// Register port.
	input  wire asc_pkg::asc_bus_req_t bus_in,
	output logic [7:0]                rdata_out,
	// Pins and pulse generator.
	input  wire logic [3:0]           user_pin_in,
	input  wire logic                 pulse_in,
	// Switch drives.
	output asc_pkg::asc_switch_t      switch_out
);

	logic [7:0] switch_control_r, switch_control_nxt;
	logic [7:0] pin_assign_r, pin_assign_nxt;
	logic [7:0] pin_level_r, pin_level_nxt;
	logic [7:0] pulse_cfg_r, pulse_cfg_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [3:0] pin_active;
	logic [3:0] pin_live;
	logic [3:0] sw_term;
	logic       pulse_a_on;
	logic       pulse_b_on;
	logic       pulse_co1_on;
	logic       pulse_co2_on;

	// Pulse sense from a high/low select pair: high selects high, low selects low, none gives off.
	function automatic logic pair_sense(input logic hi, input logic lo, input logic p);
		pair_sense = (hi & p) | (lo & ~p);
	endfunction : pair_sense

	// OR of all assigned, asserted pins for one switch.
	function automatic logic pins_for(input logic [7:0] assign_v, input logic [3:0] act, input int sw);
		logic r;
		r = 1'b0;
		for (int i = 0; i < asc_pkg::ASC_NUM_PINS; i++) begin
			if (assign_v[2*i +: 2] == 2'(sw))
				r = r | act[i];
		end
		pins_for = r;
	endfunction : pins_for

	always_comb begin
		switch_control_nxt = switch_control_r;
		pin_assign_nxt     = pin_assign_r;
		pin_level_nxt      = pin_level_r;
		pulse_cfg_nxt      = pulse_cfg_r;
		rdata_nxt          = asc_pkg::ASC_RDATA_IDLE;
		if (bus_in.wr) begin
			if (bus_in.addr == asc_pkg::ASC_SWITCH_CONTROL_ADDR) begin
				switch_control_nxt = bus_in.wdata & asc_pkg::ASC_SWCTL_MASK;
			end else if (bus_in.addr == asc_pkg::ASC_PIN_ASSIGN_ADDR) begin
				pin_assign_nxt = bus_in.wdata;
			end else if (bus_in.addr == asc_pkg::ASC_PIN_LEVEL_ADDR) begin
				pin_level_nxt = bus_in.wdata;
			end else if (bus_in.addr == asc_pkg::ASC_PULSE_CFG_ADDR) begin
				pulse_cfg_nxt = bus_in.wdata;
			end
		end
		if (bus_in.rd) begin
			if (bus_in.addr == asc_pkg::ASC_SWITCH_CONTROL_ADDR) begin
				rdata_nxt = switch_control_r;
			end else if (bus_in.addr == asc_pkg::ASC_PIN_ASSIGN_ADDR) begin
				rdata_nxt = pin_assign_r;
			end else if (bus_in.addr == asc_pkg::ASC_PIN_LEVEL_ADDR) begin
				rdata_nxt = pin_level_r;
			end else if (bus_in.addr == asc_pkg::ASC_PULSE_CFG_ADDR) begin
				rdata_nxt = pulse_cfg_r;
			end else if (bus_in.addr == asc_pkg::ASC_SWITCH_STATE_ADDR) begin
				rdata_nxt = {asc_pkg::ASC_STATE_PAD, switch_out};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			switch_control_r <= asc_pkg::ASC_RESET_VAL;
			pin_assign_r     <= asc_pkg::ASC_RESET_VAL;
			pin_level_r      <= asc_pkg::ASC_RESET_VAL;
			pulse_cfg_r      <= asc_pkg::ASC_RESET_VAL;
			rdata_r          <= asc_pkg::ASC_RESET_VAL;
		end else begin
			switch_control_r <= switch_control_nxt;
			pin_assign_r     <= pin_assign_nxt;
			pin_level_r      <= pin_level_nxt;
			pulse_cfg_r      <= pulse_cfg_nxt;
			rdata_r          <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;

	always_comb begin
		// A pin level bit of 1 means the pin asserts high.
		pin_active   = ~(user_pin_in ^ pin_level_r[asc_pkg::ASC_LEVEL_LSB +: asc_pkg::ASC_NUM_PINS]);
		// Pins whose assignment enable bit is clear add nothing.
		pin_live     = pin_active & pin_level_r[asc_pkg::ASC_ENABLE_LSB +: asc_pkg::ASC_NUM_PINS];
		pulse_a_on   = pair_sense(pulse_cfg_r[asc_pkg::ASC_PA_HIGH_BIT],
			pulse_cfg_r[asc_pkg::ASC_PA_LOW_BIT], pulse_in);
		pulse_b_on   = pair_sense(pulse_cfg_r[asc_pkg::ASC_PB_HIGH_BIT],
			pulse_cfg_r[asc_pkg::ASC_PB_LOW_BIT], pulse_in);
		pulse_co1_on = pulse_cfg_r[asc_pkg::ASC_PCO1_BIT] & pulse_in;
		pulse_co2_on = pulse_cfg_r[asc_pkg::ASC_PCO2_BIT] & pulse_in;
		sw_term[asc_pkg::ASC_SW_A]   = switch_control_r[asc_pkg::ASC_BUF_A_BIT] | pulse_a_on
			| (pins_for(pin_assign_r, pin_live, asc_pkg::ASC_SW_A));
		sw_term[asc_pkg::ASC_SW_B]   = switch_control_r[asc_pkg::ASC_BUF_B_BIT] | pulse_b_on
			| (pins_for(pin_assign_r, pin_live, asc_pkg::ASC_SW_B));
		sw_term[asc_pkg::ASC_SW_CO1] = switch_control_r[asc_pkg::ASC_CO1_DRIVE_BIT] | pulse_co1_on
			| (pins_for(pin_assign_r, pin_live, asc_pkg::ASC_SW_CO1));
		sw_term[asc_pkg::ASC_SW_CO2] = switch_control_r[asc_pkg::ASC_CO2_DRIVE_BIT] | pulse_co2_on
			| (pins_for(pin_assign_r, pin_live, asc_pkg::ASC_SW_CO2));
		switch_out.buf_a_closed  = sw_term[asc_pkg::ASC_SW_A];
		switch_out.buf_b_closed  = sw_term[asc_pkg::ASC_SW_B];
		switch_out.co1_no_closed = sw_term[asc_pkg::ASC_SW_CO1];
		switch_out.co1_nc_closed = switch_control_r[asc_pkg::ASC_CO1_MODE_BIT]
			? ~sw_term[asc_pkg::ASC_SW_CO1] : sw_term[asc_pkg::ASC_SW_CO1];
		switch_out.co2_no_closed = sw_term[asc_pkg::ASC_SW_CO2];
		switch_out.co2_nc_closed = switch_control_r[asc_pkg::ASC_CO2_MODE_BIT]
			? ~sw_term[asc_pkg::ASC_SW_CO2] : sw_term[asc_pkg::ASC_SW_CO2];
	end

endmodule : asc_top
`default_nettype wire

// ---- verification/asc_props.sv ----
// Checker for the analog switch control block.
// Sees only the top ports; shadows the control register from bus writes.
`timescale 1ns/10ps
`default_nettype none
module asc_props (
	input wire logic                  clk_in,
	input wire logic                  srst_in,
	input wire asc_pkg::asc_bus_req_t bus_in,
	input wire logic [7:0]            rdata_out,
	input wire logic [3:0]            user_pin_in,
	input wire logic                  pulse_in,
	input wire asc_pkg::asc_switch_t  switch_out
);
	logic [7:0] ctl_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	always_ff @(posedge clk_in) begin
		if (srst_in) ctl_r <= 8'h00;
		else if (bus_in.wr && bus_in.addr == 4'h0) ctl_r <= bus_in.wdata & 8'hfc;
	end
	a_reset_all_open: assert property ($fell(srst_in) |-> switch_out == 6'h00) else $error("closed after reset");
	a_read_idle_zero: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00) else $error("stray read data");
	a_read_ctl_value: assert property (bus_in.rd && bus_in.addr == 4'h0 |=> rdata_out == $past(ctl_r)) else $error("bad read");
	a_buf_a_bit: assert property (ctl_r[7] |-> switch_out.buf_a_closed) else $error("buffer a open");
	a_buf_b_bit: assert property (ctl_r[6] |-> switch_out.buf_b_closed) else $error("buffer b open");
	a_co1_mode: assert property ((switch_out.co1_no_closed ^ switch_out.co1_nc_closed) == ctl_r[5]) else $error("co1 mode");
	a_co1_drive: assert property (ctl_r[4] |-> switch_out.co1_no_closed) else $error("co1 drive");
	a_co2_mode: assert property ((switch_out.co2_no_closed ^ switch_out.co2_nc_closed) == ctl_r[3]) else $error("co2 mode");
	a_co2_drive: assert property (ctl_r[2] |-> switch_out.co2_no_closed) else $error("co2 drive");
endmodule : asc_props
bind asc_top asc_props u_props (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in), .rdata_out(rdata_out),
	.user_pin_in(user_pin_in), .pulse_in(pulse_in), .switch_out(switch_out));
`default_nettype wire

// ---- verification/asc_top_tb_top.sv ----
// Testbench for the analog switch control block.
// Drives the register port, user pins and pulse input directly.
`timescale 1ns/10ps
`default_nettype none
module asc_top_tb_top;
	logic                  clk_in, srst_in, pulse_in;
	logic [3:0]            user_pin_in;
	logic [7:0]            rdata_out;
	int                    err_count, samples_checked;
	asc_pkg::asc_bus_req_t bus_in;
	asc_pkg::asc_switch_t  switch_out;
	asc_top DUT (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in), .rdata_out(rdata_out),
		.user_pin_in(user_pin_in), .pulse_in(pulse_in), .switch_out(switch_out));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// A write when w is set, otherwise a read whose data is compared with d.
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_in <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_in);
		bus_in <= '0;
		#1 if (!w) chk(rdata_out, d);
	endtask : acc
	task automatic sw(input logic [3:0] p, input logic q, input logic [7:0] exp);
		@(posedge clk_in);
		user_pin_in <= p;
		pulse_in <= q;
		#1 chk({2'b00, switch_out}, exp);
	endtask : sw
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (3000) @(posedge clk_in);
		err_count++;
		conclude();
	end
	initial begin
		srst_in = 1'b1;
		bus_in = '0;
		user_pin_in = 4'h0;
		pulse_in = 1'b0;
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		acc(1'b0, 4'h0, 8'h00);
		sw(4'h0, 1'b0, 8'h00);
		acc(1'b1, 4'h0, 8'hff);
		acc(1'b0, 4'h0, 8'hfc);
		sw(4'h0, 1'b0, 8'h3a);
		acc(1'b0, 4'h4, 8'h3a);
		acc(1'b1, 4'h0, 8'h24);
		sw(4'h0, 1'b0, 8'h07);
		acc(1'b1, 4'h0, 8'h00);
		acc(1'b1, 4'h1, 8'he4);
		acc(1'b1, 4'h2, 8'hf1);
		acc(1'b0, 4'h1, 8'he4);
		acc(1'b0, 4'h2, 8'hf1);
		sw(4'h1, 1'b0, 8'h3f);
		sw(4'he, 1'b0, 8'h00);
		acc(1'b1, 4'h2, 8'h01);
		sw(4'h1, 1'b0, 8'h00);
		acc(1'b1, 4'h3, 8'h01);
		sw(4'h0, 1'b1, 8'h20);
		sw(4'h0, 1'b0, 8'h00);
		acc(1'b1, 4'h3, 8'h02);
		sw(4'h0, 1'b0, 8'h20);
		acc(1'b1, 4'h3, 8'h0c);
		sw(4'h0, 1'b1, 8'h10);
		acc(1'b1, 4'h3, 8'h30);
		acc(1'b0, 4'h3, 8'h30);
		sw(4'h0, 1'b1, 8'h0f);
		acc(1'b1, 4'h3, 8'h00);
		sw(4'h0, 1'b1, 8'h00);
		acc(1'b0, 4'h5, 8'h00);
		// Load all six control bits and both changeover pulse bits, then pulse reset in mid-run and expect all switches open again.
		acc(1'b1, 4'h0, 8'hfc);
		acc(1'b1, 4'h3, 8'h30);
		sw(4'h0, 1'b1, 8'h3a);
		@(posedge clk_in);
		srst_in <= 1'b1;
		@(posedge clk_in);
		srst_in <= 1'b0;
		sw(4'h0, 1'b1, 8'h00);
		acc(1'b0, 4'h0, 8'h00);
		acc(1'b0, 4'h3, 8'h00);
		conclude();
	end
endmodule : asc_top_tb_top
`default_nettype wire
